// *** include/sdc_dith_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface sdc_dith_if;
    logic                 enable;
    sdc_pkg::sdc_amp_type amp;
    sdc_pkg::sdc_per_type period;
    sdc_pkg::sdc_cur_type setpoint;
    sdc_pkg::sdc_cur_type target;

    modport ctl  (output enable, output amp, output period, output setpoint, input target);
    modport dith (input enable, input amp, input period, input setpoint, output target);
endinterface

`default_nettype wire

// *** include/sdc_pkg.sv ***
package sdc_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int SDC_FRAME_BITS = 32;
    localparam int SDC_CUR_BITS   = 11;
    localparam int SDC_AMP_BITS   = 8;
    localparam int SDC_PER_BITS   = 8;
    localparam int SDC_CH_NUM     = 2;

    typedef logic [SDC_CUR_BITS-1:0] sdc_cur_type;
    typedef logic [SDC_AMP_BITS-1:0] sdc_amp_type;
    typedef logic [SDC_PER_BITS-1:0] sdc_per_type;
    typedef logic [2:0]              sdc_addr_type;

    // ----------------------------------------------------------------
    // frame layout: [31] write, [30:28] address, [15:0] data
    // ----------------------------------------------------------------
    localparam int SDC_FRM_WR_POS   = 31;
    localparam int SDC_FRM_ADDR_LSB = 28;
    localparam int SDC_FRM_DATA_MSB = 15;
    localparam logic [5:0] SDC_FRAME_CNT = 6'h20;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam sdc_addr_type SDC_ADDR_CONFIG = 3'h0;
    localparam sdc_addr_type SDC_ADDR_SETPT0 = 3'h1;
    localparam sdc_addr_type SDC_ADDR_SETPT1 = 3'h2;
    localparam sdc_addr_type SDC_ADDR_DITHER = 3'h3;
    localparam sdc_addr_type SDC_ADDR_DIAG   = 3'h4;

    // ----------------------------------------------------------------
    // config fields and reset values
    // ----------------------------------------------------------------
    localparam int SDC_CFG_EN_LSB     = 0;
    localparam int SDC_CFG_LS_LSB     = 2;
    localparam int SDC_CFG_DITH_LSB   = 4;
    localparam int SDC_DITH_PER_LSB   = 8;
    localparam logic [5:0]  SDC_CONFIG_RST = 6'h00;
    localparam sdc_cur_type SDC_SETPT_RST  = 11'h000;
    localparam sdc_amp_type SDC_AMP_RST    = 8'h00;
    localparam sdc_per_type SDC_PER_RST    = 8'h00;

    // ----------------------------------------------------------------
    // diagnosis fields
    // ----------------------------------------------------------------
    localparam int SDC_DIAG_OT_LSB   = 0;
    localparam int SDC_DIAG_FRM_POS  = 2;
    localparam int SDC_DIAG_EN_POS   = 3;
    localparam int SDC_DIAG_LINE_POS = 4;

endpackage

// *** rtl/sdc_dither.sv ***
`timescale 1ns/100ps
`default_nettype none

module sdc_dither
    import sdc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    sdc_dith_if.dith  dif
);

    // ----------------------------------------------------------------
    // triangle generator
    // ----------------------------------------------------------------
    sdc_per_type       div_reg,  div_next;
    logic signed [9:0] offs_reg, offs_next;
    logic              up_reg,   up_next;
    sdc_cur_type       tgt_reg,  tgt_next;
    logic signed [9:0] amp_s;
    logic signed [12:0] sum;

    always_comb begin
        amp_s     = signed'({2'b00, dif.amp});
        div_next  = div_reg;
        offs_next = offs_reg;
        up_next   = up_reg;
        if (!dif.enable) begin
            div_next  = '0;
            offs_next = '0;
            up_next   = 1'b1;
        end else if (div_reg >= dif.period) begin
            // one step per period+1 cycles sets the frequency
            div_next = '0;
            if (up_reg) begin
                if (offs_reg >= amp_s) begin
                    up_next   = 1'b0;
                    // zero amplitude must not leave a one-step ripple
                    offs_next = (offs_reg > -amp_s) ? offs_reg - 10'sd1 : offs_reg;
                end else begin
                    offs_next = offs_reg + 10'sd1;
                end
            end else begin
                if (offs_reg <= -amp_s) begin
                    up_next   = 1'b1;
                    offs_next = (offs_reg < amp_s) ? offs_reg + 10'sd1 : offs_reg;
                end else begin
                    offs_next = offs_reg - 10'sd1;
                end
            end
        end else begin
            div_next = div_reg + 8'h01;
        end
        // clamp instead of wrap near both ends of the range
        sum = signed'({2'b00, dif.setpoint}) + 13'(offs_reg);
        if (sum < 13'sd0) begin
            tgt_next = '0;
        end else if (sum > 13'sd2047) begin
            tgt_next = 11'h7FF;
        end else begin
            tgt_next = sum[10:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg  <= '0;
            offs_reg <= '0;
            up_reg   <= 1'b1;
            tgt_reg  <= '0;
        end else begin
            div_reg  <= div_next;
            offs_reg <= offs_next;
            up_reg   <= up_next;
            tgt_reg  <= tgt_next;
        end
    end

    assign dif.target = tgt_reg;

endmodule

`default_nettype wire

// *** rtl/sdc_top.sv ***
// Summary of operation
// - host exchanges 32-bit serial frames to command channels and read diagnosis
// - reset low disables all channels and returns registers to defaults
// - enable low keeps channels off; serial interface still works fully
// - fault output asserts whenever any fault is detected
// - each channel takes an unsigned 11-bit average current setpoint
// - optional triangular dither with programmable amplitude and frequency
// - each channel independently set high-side or low-side
// - overtemperature turns off only the affected channel
// - fault output is open drain, only pulls low
`timescale 1ns/100ps
`default_nettype none

module sdc_top
    import sdc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              reset_in_low,
    input  wire logic              enable_in,
    input  wire logic              spi_sclk,
    input  wire logic              spi_cs_n,
    input  wire logic              spi_mosi,
    output var  logic              spi_miso_o,
    output var  logic              spi_miso_oe,
    input  wire logic [1:0]        overtemp_in,
    input  wire logic              fault_alert_in,
    output var  logic              fault_alert_out_o,
    output var  logic              fault_alert_out_oe,
    output var  logic [1:0]        ch_on,
    output var  logic [1:0]        ch_low_side,
    output var  sdc_pkg::sdc_cur_type ch_current0,
    output var  sdc_pkg::sdc_cur_type ch_current1
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic         soft_rst_n;
    logic         sclk_reg,  sclk_next;
    logic         cs_reg,    cs_next;
    logic [5:0]   cnt_reg,   cnt_next;
    logic [31:0]  rx_reg,    rx_next;
    logic [31:0]  tx_reg,    tx_next;
    sdc_addr_type rda_reg,   rda_next;
    logic [5:0]   cfg_reg,   cfg_next;
    sdc_cur_type  sp_reg [SDC_CH_NUM];
    sdc_cur_type  sp_next [SDC_CH_NUM];
    sdc_amp_type  amp_reg,   amp_next;
    sdc_per_type  per_reg,   per_next;
    logic [1:0]   ot_reg,    ot_next;
    logic         ferr_reg,  ferr_next;
    logic [1:0]   on_reg,    on_next;
    logic         flt_reg,   flt_next;

    logic         rise, fall, start, stop, diag_clr, wr_hit;
    sdc_addr_type waddr;
    logic [15:0]  wdata;
    sdc_cur_type  tgt [SDC_CH_NUM];

    // register reset and the reset pin act alike
    assign soft_rst_n = rst_n & reset_in_low;

    // ----------------------------------------------------------------
    // readback decode
    // ----------------------------------------------------------------
    function automatic logic [15:0] rd_data(input sdc_addr_type a);
        logic [15:0] d;
        d = 16'h0000;
        case (a)
            SDC_ADDR_CONFIG: d = {10'h000, cfg_reg};
            SDC_ADDR_SETPT0: d = {5'h00, sp_reg[0]};
            SDC_ADDR_SETPT1: d = {5'h00, sp_reg[1]};
            SDC_ADDR_DITHER: d = {per_reg, amp_reg};
            SDC_ADDR_DIAG:   d = {11'h000, fault_alert_in, enable_in, ferr_reg, ot_reg};
            default:         d = 16'h0000;
        endcase
        return d;
    endfunction

    // ----------------------------------------------------------------
    // serial frame engine, mode 0, inputs already synchronous
    // ----------------------------------------------------------------
    always_comb begin
        rise     = spi_sclk & ~sclk_reg;
        fall     = ~spi_sclk & sclk_reg;
        start    = ~spi_cs_n & cs_reg;
        stop     = spi_cs_n & ~cs_reg;
        waddr    = rx_reg[SDC_FRM_ADDR_LSB +: 3];
        wdata    = rx_reg[SDC_FRM_DATA_MSB:0];
        wr_hit   = stop & (cnt_reg == SDC_FRAME_CNT) & rx_reg[SDC_FRM_WR_POS];
        // flags clear when the frame that carries them starts
        diag_clr = start & (rda_reg == SDC_ADDR_DIAG);
        sclk_next = spi_sclk;
        cs_next   = spi_cs_n;
        cnt_next  = cnt_reg;
        rx_next   = rx_reg;
        tx_next   = tx_reg;
        rda_next  = rda_reg;
        if (start) begin
            cnt_next = '0;
            tx_next  = {1'b0, rda_reg, 12'h000, rd_data(rda_reg)};
        end else if (!spi_cs_n) begin
            if (rise && cnt_reg < SDC_FRAME_CNT) begin
                rx_next  = {rx_reg[30:0], spi_mosi};
                cnt_next = cnt_reg + 6'h01;
            end
            if (fall && cnt_reg != 6'h00) begin
                tx_next = {tx_reg[30:0], 1'b0};
            end
        end
        if (stop && cnt_reg == SDC_FRAME_CNT) begin
            rda_next = waddr;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_comb begin
        cfg_next   = cfg_reg;
        sp_next[0] = sp_reg[0];
        sp_next[1] = sp_reg[1];
        amp_next   = amp_reg;
        per_next   = per_reg;
        if (wr_hit) begin
            case (waddr)
                SDC_ADDR_CONFIG: cfg_next   = wdata[5:0];
                SDC_ADDR_SETPT0: sp_next[0] = wdata[10:0];
                SDC_ADDR_SETPT1: sp_next[1] = wdata[10:0];
                SDC_ADDR_DITHER: begin
                    amp_next = wdata[SDC_AMP_BITS-1:0];
                    per_next = wdata[SDC_DITH_PER_LSB +: SDC_PER_BITS];
                end
                default: cfg_next = cfg_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // faults and channel gating
    // ----------------------------------------------------------------
    always_comb begin
        // set wins over a clear in the same cycle
        ot_next   = (ot_reg & {2{~diag_clr}}) | overtemp_in;
        ferr_next = (ferr_reg & ~diag_clr) | (stop & (cnt_reg != SDC_FRAME_CNT));
        // a latched overtemperature holds only its own channel off
        on_next   = {2{enable_in}} & cfg_reg[SDC_CFG_EN_LSB +: 2] & ~ot_reg;
        flt_next  = |ot_reg | ferr_reg;
    end

    always_ff @(posedge clk) begin
        if (!soft_rst_n) begin
            sclk_reg  <= 1'b0;
            cs_reg    <= 1'b1;
            cnt_reg   <= '0;
            rx_reg    <= '0;
            tx_reg    <= '0;
            rda_reg   <= SDC_ADDR_CONFIG;
            cfg_reg   <= SDC_CONFIG_RST;
            sp_reg[0] <= SDC_SETPT_RST;
            sp_reg[1] <= SDC_SETPT_RST;
            amp_reg   <= SDC_AMP_RST;
            per_reg   <= SDC_PER_RST;
            ot_reg    <= '0;
            ferr_reg  <= 1'b0;
            on_reg    <= '0;
            flt_reg   <= 1'b0;
        end else begin
            sclk_reg  <= sclk_next;
            cs_reg    <= cs_next;
            cnt_reg   <= cnt_next;
            rx_reg    <= rx_next;
            tx_reg    <= tx_next;
            rda_reg   <= rda_next;
            cfg_reg   <= cfg_next;
            sp_reg[0] <= sp_next[0];
            sp_reg[1] <= sp_next[1];
            amp_reg   <= amp_next;
            per_reg   <= per_next;
            ot_reg    <= ot_next;
            ferr_reg  <= ferr_next;
            on_reg    <= on_next;
            flt_reg   <= flt_next;
        end
    end

    // ----------------------------------------------------------------
    // per-channel dither
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < SDC_CH_NUM; i++) begin : g_ch
            sdc_dith_if dif ();
            // dither runs only while the channel drives
            assign dif.enable   = on_reg[i] & cfg_reg[SDC_CFG_DITH_LSB + i];
            assign dif.amp      = amp_reg;
            assign dif.period   = per_reg;
            assign dif.setpoint = sp_reg[i];
            assign tgt[i]       = dif.target;
            sdc_dither u_dith (
                .clk   (clk),
                .rst_n (soft_rst_n),
                .dif   (dif)
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign spi_miso_o         = tx_reg[31];
    assign spi_miso_oe        = ~spi_cs_n;
    assign ch_on              = on_reg;
    assign ch_low_side        = cfg_reg[SDC_CFG_LS_LSB +: 2];
    assign ch_current0        = on_reg[0] ? tgt[0] : SDC_SETPT_RST;
    assign ch_current1        = on_reg[1] ? tgt[1] : SDC_SETPT_RST;
    // only ever pulls low; the high level comes from outside
    assign fault_alert_out_o  = 1'b0;
    assign fault_alert_out_oe = flt_reg;

endmodule

`default_nettype wire

// *** verif/sdc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module sdc_host_model (
    input  wire logic clk,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // frame: mode 0, msb first, sclk still between frames
    // ----------------------------------------------------------------
    // three clocks per half bit leaves room for the sclk edge detector
    task automatic xfer(input logic [31:0] w, input int nb, output logic [31:0] r);
        r = '0;
        tick(1);
        cs_n = 1'b0;
        tick(3);
        for (int i = 0; i < nb; i++) begin
            mosi = w[31-i];
            tick(3);
            sclk = 1'b1;
            r = {r[30:0], miso};
            tick(3);
            sclk = 1'b0;
        end
        tick(2);
        cs_n = 1'b1;
        mosi = ~mosi;
        tick(3);
    endtask
endmodule

`default_nettype wire

// *** verif/sdc_top_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

module sdc_top_asserts (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 reset_in_low,
    input wire logic                 enable_in,
    input wire logic                 spi_sclk,
    input wire logic                 spi_cs_n,
    input wire logic                 spi_mosi,
    input wire logic                 spi_miso_o,
    input wire logic                 spi_miso_oe,
    input wire logic [1:0]           overtemp_in,
    input wire logic                 fault_alert_in,
    input wire logic                 fault_alert_out_o,
    input wire logic                 fault_alert_out_oe,
    input wire logic [1:0]           ch_on,
    input wire logic [1:0]           ch_low_side,
    input wire sdc_pkg::sdc_cur_type ch_current0,
    input wire sdc_pkg::sdc_cur_type ch_current1
);
    import sdc_pkg::*;
    // either reset pin clears the whole block
    wire logic run = rst_n && reset_in_low;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!run);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_rst_off;
        disable iff (1'b0) !run |=> ch_on == 2'b00 && !fault_alert_out_oe;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("reset left outputs active");
    property p_rel_quiet;
        disable iff (1'b0) $rose(run) |-> !fault_alert_out_oe;
    endproperty
    a_rel_quiet: assert property (p_rel_quiet) else $error("fault after release");
    property p_en_off;
        !enable_in |=> ch_on == 2'b00;
    endproperty
    a_en_off: assert property (p_en_off) else $error("channel on while disabled");
    property p_ot0;
        overtemp_in[0] |-> ##2 !ch_on[0];
    endproperty
    a_ot0: assert property (p_ot0) else $error("hot channel 0 still on");
    property p_ot1;
        overtemp_in[1] |-> ##2 !ch_on[1];
    endproperty
    a_ot1: assert property (p_ot1) else $error("hot channel 1 still on");
    property p_fault_ot;
        overtemp_in != 2'b00 |-> ##[1:3] fault_alert_out_oe;
    endproperty
    a_fault_ot: assert property (p_fault_ot) else $error("overtemp not flagged");
    property p_od;
        fault_alert_out_oe |-> fault_alert_out_o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("fault line driven high");
    property p_miso_oe;
        spi_miso_oe == !spi_cs_n;
    endproperty
    a_miso_oe: assert property (p_miso_oe) else $error("miso enable wrong");
    property p_cur_off;
        !ch_on[0] [*3] |-> ch_current0 == 11'h000;
    endproperty
    a_cur_off: assert property (p_cur_off) else $error("current on idle channel");
endmodule

bind sdc_top sdc_top_asserts u_sdc_top_asserts (
    .clk(clk), .rst_n(rst_n), .reset_in_low(reset_in_low), .enable_in(enable_in),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .overtemp_in(overtemp_in),
    .fault_alert_in(fault_alert_in), .fault_alert_out_o(fault_alert_out_o),
    .fault_alert_out_oe(fault_alert_out_oe), .ch_on(ch_on), .ch_low_side(ch_low_side),
    .ch_current0(ch_current0), .ch_current1(ch_current1)
);

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb;
    import sdc_pkg::*;
    logic        clk, rst_n, reset_in_low, enable_in, sclk, cs_n, mosi, miso_o, miso_oe;
    logic        fault_o, fault_oe;
    logic [1:0]  overtemp_in, ch_on, ch_low_side;
    logic [31:0] rx;
    sdc_cur_type cur0, cur1;
    int          n_mismatch, compares;
    // pull-ups on both shared lines
    wire logic   miso = miso_oe ? miso_o : 1'b1;
    wire logic   fault_line = fault_oe ? fault_o : 1'b1;

    sdc_top u_sdc_top (.clk(clk), .rst_n(rst_n), .reset_in_low(reset_in_low),
        .enable_in(enable_in), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .overtemp_in(overtemp_in),
        .fault_alert_in(fault_line), .fault_alert_out_o(fault_o),
        .fault_alert_out_oe(fault_oe), .ch_on(ch_on), .ch_low_side(ch_low_side),
        .ch_current0(cur0), .ch_current1(cur1));
    sdc_host_model u_sdc_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [31:0] fw(input logic w, input sdc_addr_type a,
                                       input logic [15:0] d);
        return {w, a, 12'h000, d};
    endfunction
    task automatic frm(input logic [31:0] w);
        u_sdc_host_model.xfer(w, 32, rx);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk({fault_oe, ch_on, cur0, cur1}, 25'h0);
        frm(fw(1'b0, SDC_ADDR_CONFIG, 16'h0000));
        chk(rx, fw(1'b0, SDC_ADDR_CONFIG, {10'h000, SDC_CONFIG_RST}));
        $display("test reset done");
    endtask
    task automatic t_config;
        frm(fw(1'b1, SDC_ADDR_SETPT0, 16'h07FF));
        frm(fw(1'b1, SDC_ADDR_SETPT1, 16'h0123));
        chk(rx, fw(1'b0, SDC_ADDR_SETPT0, 16'h07FF));
        for (int i = 0; i < 4; i++) begin
            frm(fw(1'b1, SDC_ADDR_CONFIG, 16'(i * 4 + 3)));
            wt(3);
            chk({ch_low_side, ch_on}, 32'(i * 4 + 3));
        end
        chk({cur0, cur1}, {11'h7FF, 11'h123});
        $display("test config done");
    endtask
    task automatic t_enable;
        enable_in = 1'b0;
        wt(4);
        chk({ch_on, cur0}, 13'h0);
        frm(fw(1'b1, SDC_ADDR_SETPT0, 16'h0400));
        frm(fw(1'b0, SDC_ADDR_SETPT0, 16'h0000));
        chk(rx, fw(1'b0, SDC_ADDR_SETPT0, 16'h0400));
        // diag is read-only; its readback must show enable low and the line released
        frm(fw(1'b1, SDC_ADDR_DIAG, 16'hFFFF));
        frm(fw(1'b0, 3'h7, 16'h0000));
        chk(rx, fw(1'b0, SDC_ADDR_DIAG, 16'h0010));
        frm(fw(1'b0, SDC_ADDR_CONFIG, 16'h0000));
        chk(rx, fw(1'b0, 3'h7, 16'h0000));
        enable_in = 1'b1;
        wt(4);
        chk({ch_on, cur0}, {2'b11, 11'h400});
        $display("test enable done");
    endtask
    task automatic t_ot;
        for (int c = 0; c < 2; c++) begin
            overtemp_in = 2'(1 << c);
            wt(4);
            chk({fault_line, fault_oe, ch_on}, {2'b01, ~overtemp_in});
            overtemp_in = 2'b00;
            frm(fw(1'b0, SDC_ADDR_DIAG, 16'h0000));
            frm(fw(1'b0, SDC_ADDR_DIAG, 16'h0000));
            chk(rx, fw(1'b0, SDC_ADDR_DIAG, {14'h0002, 2'(1 << c)}));
            // moves readback off the flags so the next read cannot clear them
            frm(fw(1'b0, SDC_ADDR_CONFIG, 16'h0000));
            chk({fault_oe, ch_on}, 3'b011);
        end
        $display("test overtemp done");
    endtask
    task automatic t_ferr;
        u_sdc_host_model.xfer(fw(1'b1, SDC_ADDR_SETPT1, 16'h0111), 31, rx);
        chk({fault_oe, cur1}, {1'b1, 11'h123});
        frm(fw(1'b0, SDC_ADDR_DIAG, 16'h0000));
        frm(fw(1'b0, SDC_ADDR_CONFIG, 16'h0000));
        chk(rx, fw(1'b0, SDC_ADDR_DIAG, 16'h000C));
        wt(3);
        chk(fault_oe, 1'b0);
        $display("test frame error done");
    endtask
    task automatic t_dith;
        sdc_cur_type mx = 11'h400;
        sdc_cur_type mn = 11'h400;
        sdc_cur_type pv = 11'h400;
        int          n = 0;
        frm(fw(1'b1, SDC_ADDR_DITHER, 16'h0304));
        frm(fw(1'b1, SDC_ADDR_CONFIG, 16'h0013));
        repeat (160) begin
            @(negedge clk);
            n += int'(cur0 !== pv);
            pv = cur0;
            if (cur0 > mx) mx = cur0;
            if (cur0 < mn) mn = cur0;
        end
        chk({mx, mn, cur1}, {11'h404, 11'h3FC, 11'h123});
        chk(32'(n > 38 && n < 42), 32'h1);
        $display("test dither done");
    endtask
    task automatic t_rst;
        reset_in_low = 1'b0;
        wt(3);
        chk({fault_oe, ch_on, cur0, cur1}, 25'h0);
        reset_in_low = 1'b1;
        frm(fw(1'b0, SDC_ADDR_DITHER, 16'h0000));
        frm(fw(1'b0, SDC_ADDR_SETPT1, 16'h0000));
        chk(rx, fw(1'b0, SDC_ADDR_DITHER, {SDC_PER_RST, SDC_AMP_RST}));
        chk({fault_oe, ch_on}, 3'b000);
        $display("test pin reset done");
    endtask

    initial begin
        rst_n = 1'b0;
        reset_in_low = 1'b1;
        enable_in = 1'b1;
        overtemp_in = 2'b00;
        n_mismatch = 0;
        compares = 0;
        wt(12);
        rst_n = 1'b1;
        t_reset();
        t_config();
        t_enable();
        t_ot();
        t_ferr();
        t_dith();
        t_rst();
        close_out();
    end
    // about six times the expected run
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule

`default_nettype wire
